/* logic/spbs_pkg.sv */
// shared constants, types and helpers of the split-port burst memory link
package spbs_pkg;

    // ========================================================================
    // widths
    // ========================================================================
    localparam int SPBS_DATA_W = 36;
    localparam int SPBS_LANE_W = 9;
    localparam int SPBS_LANES = 4;
    localparam int SPBS_BURST = 4;
    localparam int SPBS_BEAT_W = 2;
    localparam int SPBS_ADDR_W = 19;
    localparam int SPBS_LINE_W = SPBS_DATA_W * SPBS_BURST;
    localparam int SPBS_LINE_BWS_W = SPBS_LANES * SPBS_BURST;

    // ========================================================================
    // pipeline depths and stage taps, counted in positive-clock rises
    // ========================================================================
    localparam int SPBS_RD_DEPTH = 4;
    localparam int SPBS_WR_DEPTH = 3;
    // read: stage 2 gives word0 on K# and word1 on K, stage 3 word2 and word3
    localparam int SPBS_RD_TAP_EARLY = 2;
    localparam int SPBS_RD_TAP_LATE = 3;
    // write: stage 0 word0 on K, stage 1 word1 on K# and word2 on K, stage 2 word3
    localparam int SPBS_WR_TAP_FIRST = 0;
    localparam int SPBS_WR_TAP_MID = 1;
    localparam int SPBS_WR_TAP_LAST = 2;

    localparam logic [SPBS_BEAT_W-1:0] SPBS_WORD0 = 2'h0;
    localparam logic [SPBS_BEAT_W-1:0] SPBS_WORD1 = 2'h1;
    localparam logic [SPBS_BEAT_W-1:0] SPBS_WORD2 = 2'h2;
    localparam logic [SPBS_BEAT_W-1:0] SPBS_WORD3 = 2'h3;

    // ========================================================================
    // reset and idle values
    // ========================================================================
    localparam logic SPBS_SEL_OFF = 1'h1;
    localparam logic [SPBS_LANES-1:0] SPBS_BWS_NONE = 4'hF;
    localparam logic [SPBS_DATA_W-1:0] SPBS_DATA_RST = 36'h000000000;

    // ========================================================================
    // controller write sequencer, gray coded along the burst
    // ========================================================================
    typedef enum logic [2:0] {
        SPBS_WR_IDLE = 3'h0,
        SPBS_WR_ADDR = 3'h1,
        SPBS_WR_GAP = 3'h3,
        SPBS_WR_D0 = 3'h2,
        SPBS_WR_D1 = 3'h6,
        SPBS_WR_D2 = 3'h7,
        SPBS_WR_D3 = 3'h5
    } spbs_wr_state_t;

    // ========================================================================
    // lane merge: a low select takes the new lane, a high one keeps the old
    // ========================================================================
    function automatic logic [SPBS_DATA_W-1:0] spbs_lane_merge(
        input logic [SPBS_DATA_W-1:0] old_word,
        input logic [SPBS_DATA_W-1:0] new_word,
        input logic [SPBS_LANES-1:0] sel_n
    );
        logic [SPBS_DATA_W-1:0] res;
        res = old_word;
        for (int i = 0; i < SPBS_LANES; i++)
        begin
            if (!sel_n[i])
            begin
                res[i*SPBS_LANE_W +: SPBS_LANE_W] = new_word[i*SPBS_LANE_W +: SPBS_LANE_W];
            end
        end
        return res;
    endfunction : spbs_lane_merge

endpackage : spbs_pkg

/* logic/spbs_if.sv */
// link between the memory controller and the split-port burst memory
`timescale 1ns/1ps
interface spbs_if
    import spbs_pkg::*;
#(
    parameter int ADDR_W = SPBS_ADDR_W
);
    // high in a cycle whose edge is a positive-clock rise, low for a complementary rise
    logic k_rise;
    // clock levels as the controller parks them
    logic k_pos;
    logic k_neg;
    logic [ADDR_W-1:0] addr;
    logic read_port_select_n;
    logic write_port_select_n;
    logic [SPBS_DATA_W-1:0] d;
    logic [SPBS_LANES-1:0] byte_write_select_n;
    logic [SPBS_DATA_W-1:0] q;
    logic q_oe;

    modport dev (
        input k_rise,
        input k_pos,
        input k_neg,
        input addr,
        input read_port_select_n,
        input write_port_select_n,
        input d,
        input byte_write_select_n,
        output q,
        output q_oe
    );

    modport ctl (
        output k_rise,
        output k_pos,
        output k_neg,
        output addr,
        output read_port_select_n,
        output write_port_select_n,
        output d,
        output byte_write_select_n,
        input q,
        input q_oe
    );
endinterface : spbs_if

/* logic/spbs_addr_pipe.sv */
// shift line of captured burst addresses, advanced on positive-clock rises
`timescale 1ns/1ps
module spbs_addr_pipe
    import spbs_pkg::*;
#(
    parameter int DEPTH = SPBS_RD_DEPTH,
    parameter int ADDR_W = SPBS_ADDR_W
)
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic shift,
    input wire logic in_valid,
    input wire logic [ADDR_W-1:0] in_addr,
    output logic [DEPTH-1:0] valid,
    output logic [DEPTH-1:0][ADDR_W-1:0] addr
);
    if (DEPTH < 2)
    begin : g_bad_depth
        $error("spbs_addr_pipe needs at least two stages");
    end

    logic [DEPTH-1:0] valid_ff;
    logic [DEPTH-1:0][ADDR_W-1:0] addr_ff;

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            valid_ff <= '0;
        end
        else if (shift)
        begin
            valid_ff <= {valid_ff[DEPTH-2:0], in_valid};
        end
    end

    // addresses need no reset: a stage is only used while its valid bit is set
    always_ff @(posedge clk_sys)
    begin
        if (shift)
        begin
            addr_ff <= {addr_ff[DEPTH-2:0], in_addr};
        end
    end

    assign valid = valid_ff;
    assign addr = addr_ff;
endmodule : spbs_addr_pipe

/* logic/spbs_device.sv */
// memory end: split read/write ports, four-word double-rate bursts, byte lanes
`timescale 1ns/1ps
module spbs_device
    import spbs_pkg::*;
#(
    parameter int ADDR_W = SPBS_ADDR_W
)
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic ce,
    spbs_if.dev link
);
    // ========================================================================
    // parameter check
    // ========================================================================
    if (ADDR_W < 1 || ADDR_W > SPBS_ADDR_W)
    begin : g_bad_addr
        $error("spbs_device address width out of range");
    end

    localparam int WORD_AW = ADDR_W + SPBS_BEAT_W;
    localparam int MEM_DEPTH = 1 << WORD_AW;

    // ========================================================================
    // helpers
    // ========================================================================
    // word address of one beat: the captured location with the beat index as the two low bits
    function automatic logic [WORD_AW-1:0] word_index(
        input logic [ADDR_W-1:0] loc,
        input logic [SPBS_BEAT_W-1:0] beat
    );
        return {loc, beat};
    endfunction : word_index

    // ========================================================================
    // clocking
    // ========================================================================
    logic en;
    logic k_edge;

    // a low enable stands for stopped input clocks
    assign en = ce;
    assign k_edge = en & link.k_rise;

    // ========================================================================
    // request filtering on positive-clock rises
    // ========================================================================
    logic rd_last_ff;
    logic wr_last_ff;
    logic rd_go;
    logic wr_go;

    // one address bus: if both ports ask, the read wins unless it was just used,
    // which gives alternating read/write from a deselected start
    always_comb
    begin
        rd_go = ~link.read_port_select_n & ~rd_last_ff;
        wr_go = ~link.write_port_select_n & ~wr_last_ff & ~rd_go;
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rd_last_ff <= 1'b0;
            wr_last_ff <= 1'b0;
        end
        else if (k_edge)
        begin
            rd_last_ff <= rd_go;
            wr_last_ff <= wr_go;
        end
    end

    // ========================================================================
    // address pipelines
    // ========================================================================
    logic [SPBS_RD_DEPTH-1:0] rd_vld;
    logic [SPBS_RD_DEPTH-1:0][ADDR_W-1:0] rd_loc;
    logic [SPBS_WR_DEPTH-1:0] wr_vld;
    logic [SPBS_WR_DEPTH-1:0][ADDR_W-1:0] wr_loc;

    spbs_addr_pipe #(
        .DEPTH(SPBS_RD_DEPTH),
        .ADDR_W(ADDR_W)
    ) u_rd_pipe (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .shift(k_edge),
        .in_valid(rd_go),
        .in_addr(link.addr),
        .valid(rd_vld),
        .addr(rd_loc)
    );

    spbs_addr_pipe #(
        .DEPTH(SPBS_WR_DEPTH),
        .ADDR_W(ADDR_W)
    ) u_wr_pipe (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .shift(k_edge),
        .in_valid(wr_go),
        .in_addr(link.addr),
        .valid(wr_vld),
        .addr(wr_loc)
    );

    // ========================================================================
    // write beat selection
    // ========================================================================
    logic wr_hit;
    logic [WORD_AW-1:0] wr_idx;
    logic [SPBS_DATA_W-1:0] wr_word;
    logic [SPBS_DATA_W-1:0] mem [MEM_DEPTH];

    // taps are read before this edge's shift; two writes in adjacent stages cannot
    // exist, so at most one tap hits on any beat
    always_comb
    begin
        wr_hit = 1'b0;
        wr_idx = '0;
        if (link.k_rise)
        begin
            if (wr_vld[SPBS_WR_TAP_FIRST])
            begin
                wr_hit = 1'b1;
                wr_idx = word_index(wr_loc[SPBS_WR_TAP_FIRST], SPBS_WORD0);
            end
            else if (wr_vld[SPBS_WR_TAP_MID])
            begin
                wr_hit = 1'b1;
                wr_idx = word_index(wr_loc[SPBS_WR_TAP_MID], SPBS_WORD2);
            end
        end
        else
        begin
            if (wr_vld[SPBS_WR_TAP_LAST])
            begin
                wr_hit = 1'b1;
                wr_idx = word_index(wr_loc[SPBS_WR_TAP_LAST], SPBS_WORD3);
            end
            else if (wr_vld[SPBS_WR_TAP_MID])
            begin
                wr_hit = 1'b1;
                wr_idx = word_index(wr_loc[SPBS_WR_TAP_MID], SPBS_WORD1);
            end
        end
        // all-high selects give back the old word, so the beat still counts
        wr_word = spbs_lane_merge(mem[wr_idx], link.d, link.byte_write_select_n);
    end

    // data outside a burst is never looked at
    always_ff @(posedge clk_sys)
    begin
        if (en && wr_hit)
        begin
            mem[wr_idx] <= wr_word;
        end
    end

    // ========================================================================
    // read beat selection
    // ========================================================================
    logic rd_hit;
    logic [WORD_AW-1:0] rd_idx;
    logic [SPBS_DATA_W-1:0] rd_word;

    always_comb
    begin
        rd_hit = 1'b0;
        rd_idx = '0;
        if (link.k_rise)
        begin
            if (rd_vld[SPBS_RD_TAP_LATE])
            begin
                rd_hit = 1'b1;
                rd_idx = word_index(rd_loc[SPBS_RD_TAP_LATE], SPBS_WORD3);
            end
            else if (rd_vld[SPBS_RD_TAP_EARLY])
            begin
                rd_hit = 1'b1;
                rd_idx = word_index(rd_loc[SPBS_RD_TAP_EARLY], SPBS_WORD1);
            end
        end
        else
        begin
            if (rd_vld[SPBS_RD_TAP_LATE])
            begin
                rd_hit = 1'b1;
                rd_idx = word_index(rd_loc[SPBS_RD_TAP_LATE], SPBS_WORD2);
            end
            else if (rd_vld[SPBS_RD_TAP_EARLY])
            begin
                rd_hit = 1'b1;
                rd_idx = word_index(rd_loc[SPBS_RD_TAP_EARLY], SPBS_WORD0);
            end
        end
        // a beat written on this very edge is forwarded so reads see newest data
        rd_word = (wr_hit && wr_idx == rd_idx) ? wr_word : mem[rd_idx];
    end

    // ========================================================================
    // read outputs
    // ========================================================================
    logic [SPBS_DATA_W-1:0] q_ff;
    logic q_oe_ff;

    // enable drops right after the last beat, so a neighbour can take the bus
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            q_oe_ff <= 1'b0;
        end
        else if (en)
        begin
            q_oe_ff <= rd_hit;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            q_ff <= SPBS_DATA_RST;
        end
        else if (en && rd_hit)
        begin
            q_ff <= rd_word;
        end
    end

    assign link.q = q_ff;
    assign link.q_oe = q_oe_ff;
endmodule : spbs_device

/* logic/spbs_controller.sv */
// controller end: issues read and write bursts and gathers read data
`timescale 1ns/1ps
module spbs_controller
    import spbs_pkg::*;
#(
    parameter int ADDR_W = SPBS_ADDR_W
)
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [ADDR_W-1:0] cmd_addr,
    input wire logic [SPBS_LINE_W-1:0] cmd_wdata,
    input wire logic [SPBS_LINE_BWS_W-1:0] cmd_bws_n,
    output logic cmd_ready,
    output logic rsp_valid,
    output logic [SPBS_LINE_W-1:0] rsp_rdata,
    spbs_if.ctl link
);
    if (ADDR_W < 1 || ADDR_W > SPBS_ADDR_W)
    begin : g_bad_addr
        $error("spbs_controller address width out of range");
    end

    // ========================================================================
    // beat phase and command issue
    // ========================================================================
    logic k_rise_ff;
    logic k_pos_ff;
    logic k_neg_ff;
    logic rps_n_ff;
    logic wps_n_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic ready_ff;
    logic issue;
    spbs_wr_state_t state_ff;

    // commands go out only so that the device samples them on a positive rise
    assign issue = cmd_valid & ready_ff & ~k_rise_ff;

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            k_rise_ff <= 1'b0;
            rps_n_ff <= SPBS_SEL_OFF;
            wps_n_ff <= SPBS_SEL_OFF;
            addr_ff <= '0;
            ready_ff <= 1'b0;
        end
        else if (ce)
        begin
            k_rise_ff <= ~k_rise_ff;
            rps_n_ff <= ~(issue & ~cmd_write);
            wps_n_ff <= ~(issue & cmd_write);
            if (issue)
            begin
                addr_ff <= cmd_addr;
            end
            // never two reads on adjacent rises; a write waits for the last burst
            ready_ff <= k_rise_ff & rps_n_ff & (state_ff == SPBS_WR_IDLE || state_ff == SPBS_WR_D2);
        end
    end

    // clock levels keep moving while enabled and park high when stopped
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            k_pos_ff <= 1'b1;
            k_neg_ff <= 1'b1;
        end
        else
        begin
            k_pos_ff <= ce ? ~k_rise_ff : 1'b1;
            k_neg_ff <= ce ? k_rise_ff : 1'b1;
        end
    end

    // ========================================================================
    // write burst sequencer
    // ========================================================================
    logic [SPBS_LINE_W-1:0] wbuf_ff;
    logic [SPBS_LINE_BWS_W-1:0] wbws_ff;
    logic [SPBS_DATA_W-1:0] d_ff;
    logic [SPBS_LANES-1:0] bws_n_ff;
    spbs_wr_state_t nxt_state;
    logic load;
    logic [SPBS_BEAT_W-1:0] beat;

    always_comb
    begin
        nxt_state = state_ff;
        load = 1'b0;
        beat = SPBS_WORD0;
        unique case (state_ff)
            SPBS_WR_IDLE, SPBS_WR_D3: nxt_state = (issue & cmd_write) ? SPBS_WR_ADDR : SPBS_WR_IDLE;
            SPBS_WR_ADDR: nxt_state = SPBS_WR_GAP;
            SPBS_WR_GAP:
            begin
                nxt_state = SPBS_WR_D0;
                load = 1'b1;
                beat = SPBS_WORD0;
            end
            SPBS_WR_D0:
            begin
                nxt_state = SPBS_WR_D1;
                load = 1'b1;
                beat = SPBS_WORD1;
            end
            SPBS_WR_D1:
            begin
                nxt_state = SPBS_WR_D2;
                load = 1'b1;
                beat = SPBS_WORD2;
            end
            SPBS_WR_D2:
            begin
                nxt_state = SPBS_WR_D3;
                load = 1'b1;
                beat = SPBS_WORD3;
            end
            default: nxt_state = SPBS_WR_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_ff <= SPBS_WR_IDLE;
            d_ff <= SPBS_DATA_RST;
            bws_n_ff <= SPBS_BWS_NONE;
        end
        else if (ce)
        begin
            state_ff <= nxt_state;
            // four words on the rises of t+1 and t+2, selects fresh each beat
            if (load)
            begin
                d_ff <= wbuf_ff[beat*SPBS_DATA_W +: SPBS_DATA_W];
                bws_n_ff <= wbws_ff[beat*SPBS_LANES +: SPBS_LANES];
            end
            else
            begin
                bws_n_ff <= SPBS_BWS_NONE;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (ce && issue && cmd_write)
        begin
            wbuf_ff <= cmd_wdata;
            wbws_ff <= cmd_bws_n;
        end
    end

    // ========================================================================
    // read data gathering
    // ========================================================================
    logic [SPBS_BEAT_W-1:0] rcnt_ff;
    logic [SPBS_LINE_W-1:0] rdata_ff;
    logic rsp_valid_ff;

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rcnt_ff <= SPBS_WORD0;
            rdata_ff <= '0;
            rsp_valid_ff <= 1'b0;
        end
        else if (ce)
        begin
            rsp_valid_ff <= link.q_oe && rcnt_ff == SPBS_WORD3;
            if (link.q_oe)
            begin
                rdata_ff[rcnt_ff*SPBS_DATA_W +: SPBS_DATA_W] <= link.q;
                rcnt_ff <= rcnt_ff + 2'h1;
            end
            else
            begin
                rcnt_ff <= SPBS_WORD0;
            end
        end
    end

    assign cmd_ready = ready_ff;
    assign rsp_valid = rsp_valid_ff;
    assign rsp_rdata = rdata_ff;
    assign link.k_rise = k_rise_ff;
    assign link.k_pos = k_pos_ff;
    assign link.k_neg = k_neg_ff;
    assign link.addr = addr_ff;
    assign link.read_port_select_n = rps_n_ff;
    assign link.write_port_select_n = wps_n_ff;
    assign link.d = d_ff;
    assign link.byte_write_select_n = bws_n_ff;
endmodule : spbs_controller

/* dv/spbs_chk.sv */
// link assertions between the controller end and the memory end
`timescale 1ns/1ps
module spbs_chk
    import spbs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic k_rise,
    input wire logic read_port_select_n,
    input wire logic write_port_select_n,
    input wire logic [SPBS_LANES-1:0] byte_write_select_n,
    input wire logic q_oe
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // ========================================================================
    // helper: running cycles since clocks last stopped, so history is trusted
    // ========================================================================
    logic [3:0] run_ff;
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            run_ff <= 4'h0;
        else if (!ce)
            run_ff <= 4'h0;
        else if (run_ff != 4'hF)
            run_ff <= run_ff + 4'h1;
    end
    wire logic rd_go = k_rise && !read_port_select_n && ce;
    wire logic wr_go = k_rise && !write_port_select_n && ce;
    // ========================================================================
    // assertions
    // ========================================================================
    a_read_oe_window: assert property (rd_go ##1 ce [*6] |-> q_oe [*4])
        else $error("read data not driven four beats after latency");
    a_oe_has_cause: assert property ($rose(q_oe) && run_ff > 4'h8 |-> $past(rd_go, 6))
        else $error("read outputs driven with no read started");
    a_oe_four_min: assert property ($fell(q_oe) && run_ff > 4'h8 |-> $past(q_oe, 4))
        else $error("read burst shorter than four beats");
    a_sel_k_only: assert property (!read_port_select_n || !write_port_select_n |-> k_rise)
        else $error("port select outside a positive-clock beat");
    a_no_back_read: assert property (rd_go ##1 ce [*2] |-> read_port_select_n)
        else $error("reads started on consecutive positive rises");
    a_no_back_write: assert property (wr_go ##1 ce [*2] |-> write_port_select_n)
        else $error("writes started on consecutive positive rises");
    a_bws_data_beats: assert property (byte_write_select_n != SPBS_BWS_NONE && run_ff > 4'h8
        |-> $past(wr_go, 2) || $past(wr_go, 3) || $past(wr_go, 4) || $past(wr_go, 5))
        else $error("byte selects active outside write data beats");
    a_k_toggle: assert property (ce |=> k_rise != $past(k_rise))
        else $error("beat phase did not alternate");
    a_clock_freeze: assert property (!ce |=> $stable(q_oe) && $stable(k_rise))
        else $error("state moved while clocks stopped");
    a_boot_quiet: assert property ($rose(reset_n) |-> !q_oe [*6])
        else $error("read outputs driven after power-up");
endmodule : spbs_chk

/* dv/test_split_port_sram_burst_access.sv */
// bench: controller and memory joined, plus a second memory fed by a rule-breaking driver
`timescale 1ns/1ps
module test_split_port_sram_burst_access
    import spbs_pkg::*;
;
    localparam int AW = 4;
    localparam int LW = SPBS_LINE_W;
    logic clk_sys = 1'h0;
    logic reset_n = 1'h0;
    logic ce = 1'h1;
    logic cmd_valid = 1'h0;
    logic cmd_write = 1'h0;
    logic [AW-1:0] cmd_addr = 4'h0;
    logic [LW-1:0] cmd_wdata = '0;
    logic [SPBS_LINE_BWS_W-1:0] cmd_bws_n = 16'hFFFF;
    logic cmd_ready;
    logic rsp_valid;
    logic [LW-1:0] rsp_rdata;
    int n_mismatch = 0;
    int n_tests = 0;
    int cyc = 0;
    spbs_if #(.ADDR_W(AW)) link();
    spbs_if #(.ADDR_W(AW)) link_b();
    spbs_device #(.ADDR_W(AW)) i_spbs_device(.clk_sys(clk_sys), .reset_n(reset_n), .ce(ce), .link(link));
    spbs_device #(.ADDR_W(AW)) i_spbs_device_b(.clk_sys(clk_sys), .reset_n(reset_n), .ce(ce), .link(link_b));
    spbs_controller #(.ADDR_W(AW)) i_spbs_controller(.clk_sys(clk_sys), .reset_n(reset_n), .ce(ce),
        .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .cmd_bws_n(cmd_bws_n), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .link(link));
    spbs_chk u_chk(.clk_sys(clk_sys), .reset_n(reset_n), .ce(ce), .k_rise(link.k_rise),
        .read_port_select_n(link.read_port_select_n), .write_port_select_n(link.write_port_select_n),
        .byte_write_select_n(link.byte_write_select_n), .q_oe(link.q_oe));
    always #5 clk_sys = ~clk_sys;
    // second link: the bench plays the controller, beat phase toggles after reset
    always @(posedge clk_sys)
        link_b.k_rise <= #1 reset_n ? ~link_b.k_rise : 1'h0;
    // ========================================================================
    // shared tasks
    // ========================================================================
    task automatic check_eq(input logic [LW-1:0] got, input logic [LW-1:0] exp, input string what);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check_eq
    function automatic logic [LW-1:0] mk_line(input logic [7:0] s);
        logic [LW-1:0] l;
        for (int w = 0; w < SPBS_BURST; w++)
            l[w*SPBS_DATA_W +: SPBS_DATA_W] = {4{s + 8'(w), 1'h1}};
        return l;
    endfunction : mk_line
    task automatic issue(input logic wr, input logic [AW-1:0] a, input logic [LW-1:0] wd,
        input logic [SPBS_LINE_BWS_W-1:0] bw);
        int n;
        n = 0;
        cmd_write = wr;
        cmd_addr = a;
        cmd_wdata = wd;
        cmd_bws_n = bw;
        #10;
        cmd_valid = 1'h1;
        while (cmd_ready !== 1'h1 && n < 40)
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        check_eq(n < 40, 1'h1, "command not taken");
        @(posedge clk_sys);
        #1;
        cmd_valid = 1'h0;
    endtask : issue
    task automatic read_check(input logic [AW-1:0] a, input logic [LW-1:0] exp);
        int n;
        n = 0;
        issue(1'h0, a, '0, 16'hFFFF);
        while (rsp_valid !== 1'h1 && n < 30)
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        check_eq(n < 30 ? rsp_rdata : ~exp, exp, "read line");
    endtask : read_check
    // ========================================================================
    // scenarios
    // ========================================================================
    task automatic t_burst;
        issue(1'h1, 4'h3, mk_line(8'h11), 16'h0000);
        issue(1'h1, 4'h4, mk_line(8'h22), 16'h0000);
        read_check(4'h3, mk_line(8'h11));
        read_check(4'h4, mk_line(8'h22));
    endtask : t_burst
    task automatic t_lanes;
        logic [LW-1:0] e;
        e = mk_line(8'h01);
        issue(1'h1, 4'h5, e, 16'h0000);
        // beat w enables lane w only, so selects change between beats
        issue(1'h1, 4'h5, mk_line(8'h02), 16'h7BDE);
        for (int w = 0; w < SPBS_BURST; w++)
            e[w*SPBS_DATA_W + w*SPBS_LANE_W +: SPBS_LANE_W] = {8'h02 + 8'(w), 1'h1};
        read_check(4'h5, e);
        issue(1'h1, 4'h5, mk_line(8'h03), 16'hFFFF);
        read_check(4'h5, e);
    endtask : t_lanes
    task automatic t_freeze;
        logic [SPBS_DATA_W-1:0] held;
        issue(1'h0, 4'h3, '0, 16'hFFFF);
        repeat (7) @(posedge clk_sys);
        #1;
        ce = 1'h0;
        held = link.q;
        repeat (5)
        begin
            @(posedge clk_sys);
            #1;
            check_eq({link.k_pos, link.k_neg, link.q_oe, link.q}, {3'h7, held}, "frozen outputs");
        end
        ce = 1'h1;
        repeat (12) @(posedge clk_sys);
        #1;
        check_eq(rsp_rdata, mk_line(8'h11), "read across stop");
    endtask : t_freeze
    task automatic t_refuse;
        logic [7:0] cnt;
        cnt = 8'h00;
        check_eq(link_b.q_oe, 1'h0, "idle outputs");
        #5;
        if (link_b.k_rise !== 1'h0)
            #10;
        #5;
        link_b.read_port_select_n = 1'h0;
        link_b.addr = 4'h1;
        repeat (2) @(posedge clk_sys);
        #1;
        // still low on the next positive beat: a second read that must be dropped
        link_b.addr = 4'h2;
        @(posedge clk_sys);
        #1;
        link_b.read_port_select_n = 1'h1;
        repeat (14)
        begin
            @(posedge clk_sys);
            #1;
            cnt = cnt + 8'(link_b.q_oe);
        end
        check_eq(cnt, 8'h04, "read beats after double request");
    endtask : t_refuse
    // ========================================================================
    // main sequence, timeout and verdict
    // ========================================================================
    task automatic report_and_stop;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            n_mismatch++;
            report_and_stop();
        end
    end
    initial
    begin
        link_b.k_pos = 1'h1;
        link_b.k_neg = 1'h1;
        link_b.addr = 4'h0;
        link_b.read_port_select_n = 1'h1;
        link_b.write_port_select_n = 1'h1;
        link_b.d = 36'h000000000;
        link_b.byte_write_select_n = 4'hF;
        repeat (12) @(posedge clk_sys);
        #1;
        reset_n = 1'h1;
        check_eq(link.q_oe, 1'h0, "outputs after power-up");
        t_burst();
        t_lanes();
        t_freeze();
        t_refuse();
        report_and_stop();
    end
endmodule : test_split_port_sram_burst_access
